// >>> hw/pdu_pkg.sv
package pdu_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int LVL_W = 14;               // level and counter width
  localparam int PRE_W = 14;               // prescaler width

  // ---------------------------------------------------------------
  // byte addresses on the peripheral link
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_P0_HI = 2'h0;  // level a / control
  localparam logic [1:0] ADDR_P0_LO = 2'h1;
  localparam logic [1:0] ADDR_P1_HI = 2'h2;  // level b / counter
  localparam logic [1:0] ADDR_P1_LO = 2'h3;

  // ---------------------------------------------------------------
  // word field layout
  // ---------------------------------------------------------------
  localparam int LVL_LSB  = 2;             // level in bits 15..2
  localparam int CFS_BIT  = 1;
  localparam int BANK_BIT = 0;

  // ---------------------------------------------------------------
  // control register layout
  // ---------------------------------------------------------------
  localparam int CTL_RUN_BIT = 6;
  localparam int CTL_OEB_BIT = 3;
  localparam int CTL_OEA_BIT = 2;
  localparam int CTL_INV_BIT = 1;
  localparam int CTL_RES_BIT = 0;
  localparam logic [7:0] CTL_RSVD_ONES = 8'h30;
  localparam logic [7:0] CTL_RESET     = 8'h00;

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [13:0] LVL_RESET    = 14'h3fff;
  localparam logic [13:0] CNT_RESET    = 14'h0000;
  localparam logic [13:0] CNT_HALT     = 14'h0003;
  localparam logic [13:0] MIN_LVL_64   = 14'h0100;
  localparam logic [13:0] MIN_LVL_256  = 14'h0040;
  localparam logic [7:0]  POS_MASK_64  = 8'h3f;  // 64 periods per base
  localparam logic [7:0]  POS_MASK_256 = 8'hff;  // 256 periods per base

  // ---------------------------------------------------------------
  // divider codes to log2 of the resolution factor
  // ---------------------------------------------------------------
  localparam logic [2:0] DIV_PROHIBITED = 3'h7;
  localparam logic [3:0] DIV_SHIFT [7] = '{4'h1, 4'h6, 4'h7, 4'h8,
                                          4'ha, 4'hc, 4'he};

  // ---------------------------------------------------------------
  // apb map of the controller
  // ---------------------------------------------------------------
  localparam logic [11:0] APB_ACCESS = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_DIV    = 12'h008;
  localparam int ACC_DATA_LSB = 0;
  localparam int ACC_ADDR_LSB = 8;
  localparam int ACC_WR_BIT   = 16;
  localparam int STS_BUSY_BIT = 8;

  typedef enum logic [1:0] {
    PDU_IDLE    = 2'b00,
    PDU_STROBE  = 2'b01,
    PDU_CAPTURE = 2'b11
  } pdu_state_t;

endpackage

// >>> hw/pdu_link_if.sv
`timescale 1ns/1ps
interface pdu_link_if;
  logic [1:0] addr;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       div_code_bit0;
  logic       div_code_bit1;
  logic       div_code_bit2;

  modport dev (
    input  addr, wr_stb, rd_stb, wdata,
    input  div_code_bit0, div_code_bit1, div_code_bit2,
    output rdata
  );

  modport host (
    output addr, wr_stb, rd_stb, wdata,
    output div_code_bit0, div_code_bit1, div_code_bit2,
    input  rdata
  );
endinterface

// >>> hw/pdu_chan.sv
`timescale 1ns/1ps
module pdu_chan
  import pdu_pkg::*;
#(
  parameter int W = LVL_W
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] counter_i,
  input  wire logic [W-1:0] level_i,
  input  wire logic         cfs_i,
  input  wire logic         invert_i,
  input  wire logic         enable_i,
  output logic              pin_o
);

  // elaboration check: the base split is fixed to 14 bits
  if (W != 14)
  begin : g_width_check
    $error("pdu_chan supports only a 14-bit time base");
  end

  // ---------------------------------------------------------------
  // split counter into base position and reversed base index
  // ---------------------------------------------------------------
  logic [7:0] pos;
  logic [7:0] rev_idx;
  logic [7:0] coarse;
  logic [7:0] fine;
  logic [7:0] rev_cmp;
  logic       extra;
  logic       low;
  logic       valid;
  logic       raw;

  always_comb
  begin
    pos     = counter_i[7:0] & (cfs_i ? POS_MASK_256 : POS_MASK_64);
    rev_idx = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (cfs_i)
      begin
        if (i < 6) rev_idx[i] = counter_i[13-i];
      end
      else
      begin
        rev_idx[i] = counter_i[13-i];
      end
    end
    // coarse low time per base, fine bits spread over bases
    coarse = cfs_i ? level_i[13:6] : {2'h0, level_i[13:8]};
    fine   = cfs_i ? {2'h0, level_i[5:0]} : level_i[7:0];
    // counter bits 12 and 13 drop out in 12-bit use
    rev_cmp = rev_idx;
    if (level_i[1:0] == 2'h0) rev_cmp[1:0] = 2'h0;
    extra = rev_cmp < fine;
    low   = (pos < coarse) || ((pos == coarse) && extra);
    valid = level_i >= (cfs_i ? MIN_LVL_256 : MIN_LVL_64);
    raw   = valid ? ~low : 1'b0;
  end

  // ---------------------------------------------------------------
  // pin register: phase and enable
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      pin_o <= 1'b0;
    else if (!enable_i)
      pin_o <= 1'b0;
    else
      pin_o <= raw ^ invert_i;
  end

endmodule

// >>> hw/pdu_device.sv
// Operation
// - level bits 15..2, reset ones, read/write
// - counter compared with level every base
// - carrier bit zero: 64 periods, min 0x0100
// - carrier bit one: 256 periods, min 0x0040
// - out-of-range level holds output constant
// - low level bits zero drop counter 12,13
// - bank bit picks levels or control/counter
// - control bits 5,4 read one, unwritable
// - software keeps control bit 7 zero
// - run bit zero: 14-bit up counter
// - run bit one: counter holds 0x0003
// - control bit 3 enables channel-b pin
// - control bit 2 enables channel-a pin
// - control bit 1 inverts both outputs
// - resolution bit zero: one clock period
// - resolution bit one: clock times factor
// - one counter shared, 12-bit uses low bits
// - three-bit divider code, code 7 prohibited
// - upper byte parked, lower byte commits word
// - direct phase: level is low time
`timescale 1ns/1ps
module pdu_device
  import pdu_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  pdu_link_if.dev   link,
  output logic      chan_a_out_pin_o,
  output logic      chan_b_out_pin_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [13:0]      channel_a_level_reg;
  logic [13:0]      channel_b_level_reg;
  logic             cfs_a_reg;
  logic             cfs_b_reg;
  logic             bank_sel_reg;
  logic [7:0]       unit_control_reg;
  logic [13:0]      shared_timebase_counter;
  logic [13:0]      prescale_reg;
  logic [7:0]       temp_reg;
  logic [7:0]       rdata_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        sel_pair1;
  logic        sel_hi;
  logic        ctl_hit;
  logic        ctl_lo_hit;
  logic [15:0] level_a_word;
  logic [15:0] level_b_word;
  logic [15:0] cnt_word;
  logic [15:0] rd_word;
  logic [15:0] wr_word;
  logic [7:0]  ctl_image;
  logic        wr_lo;
  logic        cnt_load;

  // reverse six bits, used by the scrambled counter layout
  function automatic logic [5:0] rev6(input logic [5:0] v);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < 6; i++)
      r[i] = v[5-i];
    return r;
  endfunction

  assign sel_pair1  = link.addr[1];
  assign sel_hi     = (link.addr == ADDR_P0_HI) || (link.addr == ADDR_P1_HI);
  assign ctl_hit    = bank_sel_reg && (link.addr == ADDR_P0_HI);
  assign ctl_lo_hit = bank_sel_reg && (link.addr == ADDR_P0_LO);
  assign wr_word    = {temp_reg, link.wdata};
  assign wr_lo      = link.wr_stb && !sel_hi && !ctl_lo_hit;

  // word images seen by software
  assign level_a_word = {channel_a_level_reg, cfs_a_reg, 1'b1};
  assign level_b_word = {channel_b_level_reg, cfs_b_reg, bank_sel_reg};
  assign cnt_word     = {shared_timebase_counter[7:0],
                         rev6(shared_timebase_counter[13:8]),
                         1'b1, bank_sel_reg};
  assign ctl_image    = unit_control_reg | CTL_RSVD_ONES;

  // bank select steers the shared addresses
  always_comb
  begin
    if (!sel_pair1)
      rd_word = level_a_word;
    else if (bank_sel_reg)
      rd_word = cnt_word;
    else
      rd_word = level_b_word;
  end

  assign cnt_load = wr_lo && sel_pair1 && bank_sel_reg;

  // ---------------------------------------------------------------
  // read path and holding latch
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      temp_reg  <= 8'h00;
      rdata_reg <= 8'h00;
    end
    else if (link.rd_stb)
    begin
      if (ctl_hit)
        rdata_reg <= ctl_image;
      else if (ctl_lo_hit)
        rdata_reg <= 8'hff;
      else if (sel_hi)
      begin
        rdata_reg <= rd_word[15:8];
        temp_reg  <= rd_word[7:0];
      end
      else
        rdata_reg <= temp_reg;
    end
    else if (link.wr_stb && sel_hi && !ctl_hit)
      temp_reg <= link.wdata;
  end

  assign link.rdata = rdata_reg;

  // ---------------------------------------------------------------
  // level registers and bank bit
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      channel_a_level_reg <= LVL_RESET;
      channel_b_level_reg <= LVL_RESET;
      cfs_a_reg           <= 1'b1;
      cfs_b_reg           <= 1'b1;
      bank_sel_reg        <= 1'b1;
    end
    else if (wr_lo)
    begin
      if (!sel_pair1 && !bank_sel_reg)
      begin
        channel_a_level_reg <= wr_word[15:LVL_LSB];
        cfs_a_reg           <= wr_word[CFS_BIT];
      end
      else if (sel_pair1)
      begin
        if (!bank_sel_reg)
        begin
          channel_b_level_reg <= wr_word[15:LVL_LSB];
          cfs_b_reg           <= wr_word[CFS_BIT];
        end
        bank_sel_reg <= wr_word[BANK_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      unit_control_reg <= CTL_RESET;
    else if (link.wr_stb && ctl_hit)
      unit_control_reg <= link.wdata & ~CTL_RSVD_ONES;
  end

  // ---------------------------------------------------------------
  // resolution prescaler
  // ---------------------------------------------------------------
  logic [2:0]  div_code;
  logic [13:0] pre_mask;
  logic        res_tick;

  assign div_code = {link.div_code_bit2, link.div_code_bit1,
                     link.div_code_bit0};

  always_comb
  begin
    pre_mask = 14'h0000;
    if (div_code != DIV_PROHIBITED)
      pre_mask = 14'((15'h1 << DIV_SHIFT[div_code]) - 15'h1);
    if (!unit_control_reg[CTL_RES_BIT])
      res_tick = 1'b1;
    else if (div_code == DIV_PROHIBITED)
      res_tick = 1'b0;
    else
      res_tick = (prescale_reg & pre_mask) == pre_mask;
  end

  // free-running divider for the resolution period
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prescale_reg <= 14'h0000;
    else
      prescale_reg <= prescale_reg + 14'h0001;
  end

  // ---------------------------------------------------------------
  // shared time base
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      shared_timebase_counter <= CNT_RESET;
    else if (cnt_load)
      shared_timebase_counter <= {rev6(wr_word[7:2]), wr_word[15:8]};
    else if (unit_control_reg[CTL_RUN_BIT])
      shared_timebase_counter <= CNT_HALT;
    else if (res_tick)
      shared_timebase_counter <= shared_timebase_counter + 14'h0001;
  end

  // ---------------------------------------------------------------
  // channels on the common counter
  // ---------------------------------------------------------------
  pdu_chan #(.W(LVL_W)) u_chan_a (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .counter_i (shared_timebase_counter),
    .level_i   (channel_a_level_reg),
    .cfs_i     (cfs_a_reg),
    .invert_i  (unit_control_reg[CTL_INV_BIT]),
    .enable_i  (unit_control_reg[CTL_OEA_BIT]),
    .pin_o     (chan_a_out_pin_o)
  );

  pdu_chan #(.W(LVL_W)) u_chan_b (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .counter_i (shared_timebase_counter),
    .level_i   (channel_b_level_reg),
    .cfs_i     (cfs_b_reg),
    .invert_i  (unit_control_reg[CTL_INV_BIT]),
    .enable_i  (unit_control_reg[CTL_OEB_BIT]),
    .pin_o     (chan_b_out_pin_o)
  );

endmodule

// >>> hw/pdu_host.sv
`timescale 1ns/1ps
module pdu_host
  import pdu_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  pdu_link_if.host         link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pdu_state_t  state_reg;
  logic [1:0]  addr_reg;
  logic [7:0]  wdata_reg;
  logic        dir_wr_reg;
  logic [7:0]  rdata_reg;
  logic [2:0]  div_reg;
  logic [31:0] prdata_reg;
  logic        apb_wr;
  logic        busy;

  assign apb_wr    = psel_i && penable_i && pwrite_i;
  assign busy      = state_reg != PDU_IDLE;
  assign pready_o  = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o  = prdata_reg;

  // ---------------------------------------------------------------
  // byte access sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg  <= PDU_IDLE;
      addr_reg   <= 2'h0;
      wdata_reg  <= 8'h00;
      dir_wr_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        PDU_IDLE:
        begin
          if (apb_wr && paddr_i == APB_ACCESS)
          begin
            // software orders bytes high then low, keeping
            // levels in range and control bit 7 at zero
            addr_reg   <= pwdata_i[ACC_ADDR_LSB +: 2];
            wdata_reg  <= pwdata_i[ACC_DATA_LSB +: 8];
            dir_wr_reg <= pwdata_i[ACC_WR_BIT];
            state_reg  <= PDU_STROBE;
          end
        end
        PDU_STROBE:
          state_reg <= dir_wr_reg ? PDU_IDLE : PDU_CAPTURE;
        PDU_CAPTURE:
          state_reg <= PDU_IDLE;
        default:
          state_reg <= PDU_IDLE;
      endcase
    end
  end

  assign link.addr   = addr_reg;
  assign link.wdata  = wdata_reg;
  assign link.wr_stb = (state_reg == PDU_STROBE) && dir_wr_reg;
  assign link.rd_stb = (state_reg == PDU_STROBE) && !dir_wr_reg;

  // ---------------------------------------------------------------
  // read capture and divider code
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rdata_reg <= 8'h00;
    else if (state_reg == PDU_CAPTURE)
      rdata_reg <= link.rdata;
  end

  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      div_reg <= 3'h0;
    else if (apb_wr && paddr_i == APB_DIV)
      div_reg <= pwdata_i[2:0];
  end

  assign link.div_code_bit0 = div_reg[0];
  assign link.div_code_bit1 = div_reg[1];
  assign link.div_code_bit2 = div_reg[2];

  // ---------------------------------------------------------------
  // apb read data, loaded in the setup cycle
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      prdata_reg <= 32'h0000_0000;
    else if (psel_i && !penable_i)
    begin
      case (paddr_i)
        APB_STATUS: prdata_reg <= {23'h0, busy, rdata_reg};
        APB_DIV:    prdata_reg <= {29'h0, div_reg};
        default:    prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// >>> tb/pdu_chk.sv
`timescale 1ns/1ps
module pdu_chk
  import pdu_pkg::*;
(
  input wire logic       clock_i,
  input wire logic       reset_n_i,
  input wire logic [1:0] addr,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       div_code_bit0,
  input wire logic       div_code_bit1,
  input wire logic       div_code_bit2
);
  // ---------------------------------------------------------
  // shadow state
  // ---------------------------------------------------------
  logic       bank_reg;
  logic [7:0] ctl_reg;
  logic       hi_rd_reg;

  // bank bit follows low writes to pair one
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      bank_reg <= 1'b1;
    else if (wr_stb && addr == ADDR_P1_LO)
      bank_reg <= wdata[BANK_BIT];

  // control byte as written
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      ctl_reg <= CTL_RESET;
    else if (wr_stb && addr == ADDR_P0_HI && bank_reg)
      ctl_reg <= wdata;

  // last strobe was a high read of pair one
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      hi_rd_reg <= 1'b0;
    else if (wr_stb || rd_stb)
      hi_rd_reg <= rd_stb && addr == ADDR_P1_HI;

  // ---------------------------------------------------------
  // assertions
  // ---------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  AST_STB_EXCL:
    assert property (!(wr_stb && rd_stb))
    else $error("write and read strobe together");
  AST_STB_PULSE:
    assert property ((wr_stb || rd_stb) |=> !(wr_stb || rd_stb))
    else $error("strobe longer than one cycle");
  AST_RDATA_HOLD:
    assert property (!rd_stb |=> $stable(rdata))
    else $error("read byte changed without a read");
  AST_CTL_READ:
    assert property (rd_stb && addr == ADDR_P0_HI && bank_reg
                     |=> rdata == (ctl_reg | CTL_RSVD_ONES))
    else $error("control read wrong");
  AST_BANK1_FILL:
    assert property (rd_stb && addr == ADDR_P0_LO && bank_reg
                     |=> rdata == 8'hff)
    else $error("unused control low byte not all ones");
  AST_LO_BANK:
    assert property (rd_stb && addr == ADDR_P1_LO && hi_rd_reg
                     |=> rdata[BANK_BIT] == bank_reg)
    else $error("bank bit read wrong");
  AST_HALT_HI:
    assert property (rd_stb && addr == ADDR_P1_HI && bank_reg
                     && ctl_reg[CTL_RUN_BIT] |-> ##1 rdata == 8'h03)
    else $error("halted counter high byte wrong");
  AST_HALT_LO:
    assert property (rd_stb && addr == ADDR_P1_LO && bank_reg && hi_rd_reg
                     && ctl_reg[CTL_RUN_BIT] |=> rdata == 8'h03)
    else $error("halted counter low byte wrong");

  // main scenarios
  cover property (rd_stb && addr == ADDR_P0_HI && bank_reg);
  cover property (wr_stb && addr == ADDR_P1_LO && !wdata[BANK_BIT]);
  cover property (div_code_bit2 && div_code_bit1 && div_code_bit0);
endmodule

// >>> tb/pwm_dac_data_control_bench.sv
`timescale 1ns/1ps
module pwm_dac_data_control_bench
  import pdu_pkg::*;
();
  logic        clock_i;
  logic        reset_n_i;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  int          fails;
  int          checks_done;

  // ---------------------------------------------------------
  // design, link and checker
  // ---------------------------------------------------------
  pdu_link_if link ();
  pdu_host pdu_host_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .link(link.host));
  pdu_device pdu_device_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .link(link.dev), .chan_a_out_pin_o(pin_a), .chan_b_out_pin_o(pin_b));
  pdu_chk pdu_chk_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .addr(link.addr), .wr_stb(link.wr_stb), .rd_stb(link.rd_stb),
    .wdata(link.wdata), .rdata(link.rdata),
    .div_code_bit0(link.div_code_bit0),
    .div_code_bit1(link.div_code_bit1),
    .div_code_bit2(link.div_code_bit2));

  // 25 mhz clock
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  // ---------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer, then one idle cycle
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    q = prdata;
    chk({31'h0, pslverr}, 32'h0);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_i);
  endtask

  // byte access over the link, polled until idle
  task automatic acc(input logic w, input logic [1:0] a,
                     input logic [7:0] b, output logic [7:0] r);
    logic [31:0] q;
    apb(APB_ACCESS, 1'b1, {15'h0, w, 6'h0, a, b}, q);
    do apb(APB_STATUS, 1'b0, 32'h0, q); while (q[STS_BUSY_BIT] !== 1'b0);
    r = q[7:0];
  endtask

  task automatic lw(input logic [1:0] a, input logic [7:0] b);
    logic [7:0] r;
    acc(1'b1, a, b, r);
  endtask

  task automatic rc(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] r;
    acc(1'b0, a, 8'h00, r);
    chk({24'h0, r}, {24'h0, e});
  endtask

  // two counter reads, equal or not
  task automatic cnt2(input logic same);
    logic [7:0] x;
    logic [7:0] y;
    acc(1'b0, ADDR_P1_HI, 8'h00, x);
    acc(1'b0, ADDR_P1_HI, 8'h00, y);
    chk({31'h0, x === y}, {31'h0, same});
  endtask

  // low cycles of both pins over n clocks, sampled mid-cycle
  task automatic meas(input int n, input int lo_a, input int lo_b);
    int ca;
    int cb;
    ca = 0;
    cb = 0;
    repeat (4) @(posedge clock_i);
    repeat (n)
    begin
      @(negedge clock_i);
      ca += int'(pin_a === 1'b0);
      cb += int'(pin_b === 1'b0);
    end
    // back on the rising edge before the next bus call
    @(posedge clock_i);
    chk(ca, lo_a);
    chk(cb, lo_b);
  endtask

  // watchdog
  initial
  begin
    repeat (70000) @(posedge clock_i);
    fails++;
    $display("Error at %0t: timeout", $time);
    close_out();
  end

  // ---------------------------------------------------------
  // tests
  // ---------------------------------------------------------
  initial
  begin
    logic [31:0] q;
    fails       = 0;
    checks_done = 0;
    reset_n_i   = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'h000;
    pwdata      = 32'h0;
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    rc(ADDR_P0_HI, 8'h30);
    rc(ADDR_P0_LO, 8'hff);
    lw(ADDR_P0_HI, 8'h40);
    rc(ADDR_P0_HI, 8'h70);
    rc(ADDR_P1_HI, 8'h03);
    rc(ADDR_P1_LO, 8'h03);
    lw(ADDR_P0_HI, 8'h00);
    cnt2(1'b0);
    apb(APB_DIV, 1'b1, 32'h7, q);
    lw(ADDR_P0_HI, 8'h01);
    cnt2(1'b1);
    apb(APB_DIV, 1'b1, 32'h5, q);
    apb(APB_DIV, 1'b0, 32'h0, q);
    chk(q, 32'h5);
    apb(12'h00c, 1'b0, 32'h0, q);
    chk(q, 32'h0);
    apb(APB_DIV, 1'b1, 32'h0, q);
    // switch to the level bank
    lw(ADDR_P1_HI, 8'h00);
    lw(ADDR_P1_LO, 8'h00);
    rc(ADDR_P0_HI, 8'hff);
    rc(ADDR_P0_LO, 8'hff);
    rc(ADDR_P1_HI, 8'hff);
    rc(ADDR_P1_LO, 8'hfe);
    lw(ADDR_P1_HI, 8'h12);
    lw(ADDR_P1_LO, 8'h34);
    rc(ADDR_P1_HI, 8'h12);
    rc(ADDR_P1_LO, 8'h34);
    // level a 0x0123 wide carrier, b 0x0a05 narrow, back to bank one
    lw(ADDR_P0_HI, 8'h04);
    lw(ADDR_P0_LO, 8'h8e);
    lw(ADDR_P1_HI, 8'h28);
    lw(ADDR_P1_LO, 8'h15);
    lw(ADDR_P0_HI, 8'h0c);
    meas(16384, 32'h123, 32'ha05);
    lw(ADDR_P0_HI, 8'h0a);
    meas(16384, 16384, 16384 - 32'ha05);
    // a out of range, b 12-bit 0x0a40
    lw(ADDR_P1_HI, 8'h00);
    lw(ADDR_P1_LO, 8'h00);
    lw(ADDR_P0_HI, 8'h00);
    lw(ADDR_P0_LO, 8'h42);
    lw(ADDR_P1_HI, 8'h29);
    lw(ADDR_P1_LO, 8'h01);
    lw(ADDR_P0_HI, 8'h0e);
    meas(4096, 0, 4096 - 32'h290);
    lw(ADDR_P0_HI, 8'h0f);
    meas(8192, 0, 8192 - 32'h520);
    close_out();
  end
endmodule
